// >>> logic/mcr_regs.sv
// Notes on behaviour
// - Each 16-bit word travels high byte first, then low byte.
// - A 32-bit value spans two registers, lower word first, each high byte first.
// - Every address space numbers its items from zero.
// - Header bytes 4-5 count the bytes that follow them in the frame.
// - Holding 0x32 takes the preset value for the digital counter.
// - Writing 1 to coil 0x7F pulses a restore of web settings.
// - Writing 1 to coil 0x85 pulses a module reboot.
// - Input 0x97 reads the firmware version as a decimal, 123 meaning 1.2.3.
// - Input 0x9E reads link status: 0 no error, 1 timeout.
// - Input 0xA0 reads pair status: 0 normal, 1 timeout, 2 disconnected.
// - Holding 0xFF reads the last reset cause: 1 power-on, 2 watchdog, 3 command; the code only loads 1 at reset, and hosts can overwrite it.
// - Holding 0x101 sets the host watchdog; below 5 disables; stored nonvolatile.
// - Holding 0x102 counts watchdog events since reset and is writable.
// - Holding 0x107 sets TCP timeout seconds; below 5 disables; 0 means default.
// - Holding 0x108 sets system timeout seconds; below 30 disables; 0 means default.
// - Flash-backed registers persist writes; hosts should not write them often.
// - A failed multi-register write answers function 0x90 plus an exception code.
module mcr_regs import mcr_pkg::*; #(
  parameter int TICKS_PER_SEC = MCR_TICKS_PER_SEC,
  parameter logic [15:0] FIRMWARE_VERSION = 16'h007B,
  // Arbitrary value
  parameter logic [15:0] MODULE_NAME = 16'h1234,
  parameter logic [15:0] TCP_DEFAULT_SEC = 16'h003C,
  parameter logic [15:0] SYS_DEFAULT_SEC = 16'h003C
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Request byte stream
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  // Answer byte stream
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  // Status from pins
  input wire logic comm_timeout_in,
  input wire logic [1:0] pair_status_in,
  // Actions
  output logic restore_web_out,
  output logic restore_id_out,
  output logic reboot_out,
  output logic preset_load_out,
  output logic [15:0] counter_preset_out,
  output logic host_wd_expired_out,
  // Nonvolatile store requests
  output logic nv_write_out,
  output logic [15:0] nv_addr_out,
  output logic [15:0] nv_data_out,
  // Effective timeouts
  output logic tcp_timeout_en_out,
  output logic [15:0] tcp_timeout_sec_out,
  output logic sys_timeout_en_out,
  output logic [15:0] sys_timeout_sec_out
);
  typedef struct packed {
    mcr_state_e st;
    logic [MCR_BUF_BYTES-1:0][7:0] rxb;
    logic [MCR_BUF_BYTES-1:0][7:0] txb;
    logic [16:0] rcnt;
    logic [16:0] rtot;
    logic [4:0] tidx;
    logic [4:0] tlen;
    logic [3:0] widx;
    logic [7:0] exc;
    logic [15:0] preset;
    logic [15:0] reset_cause;
    logic [15:0] wd_period;
    logic [15:0] wd_events;
    logic [15:0] tcp_to;
    logic [15:0] sys_to;
    logic comm_s1;
    logic comm_s2;
    logic [1:0] pair_s1;
    logic [1:0] pair_s2;
    logic [31:0] tick_cnt;
    logic [15:0] wd_secs;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_last;
    logic restore_web;
    logic restore_id;
    logic reboot;
    logic preset_load;
    logic wd_expired;
    logic nv_write;
    logic [15:0] nv_addr;
    logic [15:0] nv_data;
    logic tcp_en;
    logic [15:0] tcp_sec;
    logic sys_en;
    logic [15:0] sys_sec;
  } mcr_state_s;

  mcr_state_s s;
  mcr_state_s n;
  logic [7:0] fc;
  logic [15:0] base;
  logic [15:0] cnt;
  logic [15:0] val;
  logic [15:0] cur_a;
  logic we;
  logic [15:0] wa;
  logic [15:0] wd;
  logic last_word;
  logic tick;

  function automatic logic [15:0] word_at(input logic [MCR_BUF_BYTES-1:0][7:0] b,
                                          input int i);
    return {b[i], b[i+1]};
  endfunction

  function automatic logic addr_ok(input logic [7:0] f, input logic [15:0] a);
    case (f)
      MCR_FC_READ_INPUT: return a == MCR_IR_FW_VERSION || a == MCR_IR_COMM_STATUS ||
                                a == MCR_IR_PAIR_STATUS;
      MCR_FC_WRITE_COIL: return a == MCR_COIL_RESTORE_WEB || a == MCR_COIL_RESTORE_ID ||
                                a == MCR_COIL_REBOOT;
      MCR_FC_READ_HOLD: return a == MCR_HR_COUNTER_PRESET || a == MCR_HR_RESET_CAUSE ||
                               a == MCR_HR_WD_PERIOD || a == MCR_HR_WD_EVENTS ||
                               a == MCR_HR_MODULE_NAME || a == MCR_HR_TCP_TIMEOUT ||
                               a == MCR_HR_SYS_TIMEOUT;
      default: return a == MCR_HR_COUNTER_PRESET || a == MCR_HR_RESET_CAUSE ||
                      a == MCR_HR_WD_PERIOD || a == MCR_HR_WD_EVENTS ||
                      a == MCR_HR_TCP_TIMEOUT || a == MCR_HR_SYS_TIMEOUT;
    endcase
  endfunction

  assign fc = s.rxb[MCR_PDU_FC];
  assign base = word_at(s.rxb, MCR_PDU_ADDR);
  assign val = word_at(s.rxb, MCR_PDU_CNT);
  assign cnt = (fc == MCR_FC_WRITE_COIL || fc == MCR_FC_WRITE_REG) ? 16'h0001 : val;
  assign cur_a = base + {12'h000, s.widx};
  assign last_word = {12'h000, s.widx} == cnt - 16'h0001;
  assign tick = s.tick_cnt == 32'(TICKS_PER_SEC - 1);

  always_comb begin
    logic [15:0] rd;
    logic bad_fc;
    logic bad_val;
    logic feed;
    rd = 16'h0000;
    feed = 1'b0;
    n = s;
    we = 1'b0;
    wa = cur_a;
    wd = 16'h0000;
    n.restore_web = 1'b0;
    n.restore_id = 1'b0;
    n.reboot = 1'b0;
    n.preset_load = 1'b0;
    n.wd_expired = 1'b0;
    n.nv_write = 1'b0;
    n.comm_s1 = comm_timeout_in;
    n.comm_s2 = s.comm_s1;
    n.pair_s1 = pair_status_in;
    n.pair_s2 = s.pair_s1;
    n.tcp_sec = (s.tcp_to == MCR_SETTING_RESET) ? TCP_DEFAULT_SEC : s.tcp_to;
    n.tcp_en = n.tcp_sec >= MCR_TCP_MIN;
    n.sys_sec = (s.sys_to == MCR_SETTING_RESET) ? SYS_DEFAULT_SEC : s.sys_to;
    n.sys_en = n.sys_sec >= MCR_SYS_MIN;
    n.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;
    bad_fc = !(fc inside {MCR_FC_READ_HOLD, MCR_FC_READ_INPUT, MCR_FC_WRITE_COIL,
                          MCR_FC_WRITE_REG, MCR_FC_WRITE_MULTI});
    bad_val = s.rtot > 17'(MCR_BUF_BYTES) || cnt == 16'h0000 ||
              cnt > 16'(MCR_MAX_WORDS) ||
              (fc == MCR_FC_WRITE_COIL && val != MCR_COIL_ON && val != 16'h0000) ||
              (fc == MCR_FC_WRITE_MULTI && {8'h00, s.rxb[MCR_PDU_BCNT]} != {cnt[14:0], 1'b0});
    case (s.st)
      MCR_RECV: begin
        if (rx_valid_in && s.rx_ready) begin
          if (s.rcnt < 17'(MCR_BUF_BYTES)) begin
            n.rxb[s.rcnt[4:0]] = rx_data_in;
          end
          n.rcnt = s.rcnt + 17'h0_0001;
          if (s.rcnt == 17'(MCR_HDR_LEN_LO)) begin
            n.rtot = 17'({s.rxb[MCR_HDR_LEN_LO-1], rx_data_in}) + 17'(MCR_HDR_BYTES);
          end
          if (s.rcnt >= 17'(MCR_HDR_LEN_LO) && n.rcnt == n.rtot) begin
            n.rx_ready = 1'b0;
            n.st = MCR_CHECK;
            n.widx = 4'h0;
            n.exc = 8'h00;
            n.rcnt = 17'h0_0000;
          end
        end
      end
      MCR_CHECK: begin
        n.txb[3:0] = s.rxb[3:0];
        n.txb[MCR_PDU_UNIT] = s.rxb[MCR_PDU_UNIT];
        n.txb[MCR_PDU_FC] = fc;
        if (s.widx == 4'h0 && bad_fc) begin
          n.exc = MCR_EXC_BAD_FUNC;
        end else if (s.widx == 4'h0 && bad_val) begin
          n.exc = MCR_EXC_BAD_VALUE;
        end else if (!addr_ok(fc, cur_a)) begin
          n.exc = MCR_EXC_BAD_ADDR;
        end
        if (n.exc != 8'h00) begin
          // error answer sets the top function bit
          n.txb[MCR_PDU_FC] = fc | MCR_FC_ERROR;
          n.txb[MCR_PDU_ADDR] = n.exc;
          n.txb[4] = 8'h00;
          n.txb[5] = 8'h03;
          n.tlen = 5'(MCR_EXC_LAST);
          n.tidx = 5'h00;
          n.st = MCR_SEND;
        end else if (last_word) begin
          n.widx = 4'h0;
          n.st = MCR_EXEC;
          // Any request that passes every check without an exception feeds the host watchdog
          feed = 1'b1;
        end else begin
          n.widx = s.widx + 4'h1;
        end
      end
      MCR_EXEC: begin
        n.txb[4] = 8'h00;
        if (fc == MCR_FC_READ_HOLD || fc == MCR_FC_READ_INPUT) begin
          if (fc == MCR_FC_READ_INPUT) begin
            case (cur_a)
              MCR_IR_FW_VERSION: rd = FIRMWARE_VERSION;
              MCR_IR_COMM_STATUS: rd = {15'h0000, s.comm_s2};
              default: rd = {14'h0000, s.pair_s2};
            endcase
          end else begin
            case (cur_a)
              MCR_HR_COUNTER_PRESET: rd = s.preset;
              MCR_HR_RESET_CAUSE: rd = s.reset_cause;
              MCR_HR_WD_PERIOD: rd = s.wd_period;
              MCR_HR_WD_EVENTS: rd = s.wd_events;
              MCR_HR_MODULE_NAME: rd = MODULE_NAME;
              MCR_HR_TCP_TIMEOUT: rd = s.tcp_to;
              default: rd = s.sys_to;
            endcase
          end
          // words in address order, low word first
          n.txb[5'(MCR_PDU_RD_DATA + 2 * int'(s.widx))] = rd[15:8];
          n.txb[5'(MCR_PDU_RD_DATA + 2 * int'(s.widx) + 1)] = rd[7:0];
          n.txb[MCR_PDU_ADDR] = {cnt[6:0], 1'b0};
          n.txb[5] = 8'(3 + 2 * int'(cnt[3:0]));
          n.tlen = 5'(MCR_PDU_RD_DATA - 1 + 2 * int'(cnt[3:0]));
        end else begin
          n.txb[MCR_ECHO_LAST:MCR_PDU_ADDR] = s.rxb[MCR_ECHO_LAST:MCR_PDU_ADDR];
          n.txb[5] = 8'h06;
          n.tlen = 5'(MCR_ECHO_LAST);
          if (fc == MCR_FC_WRITE_COIL) begin
            n.restore_web = val == MCR_COIL_ON && cur_a == MCR_COIL_RESTORE_WEB;
            n.restore_id = val == MCR_COIL_ON && cur_a == MCR_COIL_RESTORE_ID;
            n.reboot = val == MCR_COIL_ON && cur_a == MCR_COIL_REBOOT;
          end else begin
            we = 1'b1;
            wd = (fc == MCR_FC_WRITE_REG) ? val
                 : word_at(s.rxb, MCR_PDU_DATA + 2 * int'(s.widx));
          end
        end
        if (last_word) begin
          n.tidx = 5'h00;
          n.st = MCR_SEND;
        end else begin
          n.widx = s.widx + 4'h1;
        end
      end
      MCR_SEND: begin
        if (!s.tx_valid) begin
          n.tx_valid = 1'b1;
          n.tx_data = s.txb[s.tidx];
          n.tx_last = s.tidx == s.tlen;
        end else if (tx_ready_in) begin
          if (s.tx_last) begin
            n.tx_valid = 1'b0;
            n.tx_last = 1'b0;
            n.rx_ready = 1'b1;
            n.st = MCR_RECV;
          end else begin
            n.tidx = s.tidx + 5'h01;
            n.tx_data = s.txb[n.tidx];
            n.tx_last = n.tidx == s.tlen;
          end
        end
      end
      default: n.st = MCR_RECV;
    endcase
    if (we) begin
      case (wa)
        MCR_HR_COUNTER_PRESET: begin
          n.preset = wd;
          n.preset_load = 1'b1;
        end
        MCR_HR_RESET_CAUSE: n.reset_cause = wd;
        MCR_HR_WD_PERIOD: n.wd_period = wd;
        MCR_HR_WD_EVENTS: n.wd_events = wd;
        MCR_HR_TCP_TIMEOUT: n.tcp_to = wd;
        default: n.sys_to = wd;
      endcase
      // flash-backed settings go to the store
      if (wa == MCR_HR_WD_PERIOD || wa == MCR_HR_TCP_TIMEOUT || wa == MCR_HR_SYS_TIMEOUT) begin
        n.nv_write = 1'b1;
        n.nv_addr = wa;
        n.nv_data = wd;
      end
    end
    // enabled from five seconds up
    // A feed in a tick cycle must still restart the count
    if (s.wd_period < MCR_WD_MIN || feed) begin
      n.wd_secs = 16'h0000;
    end else if (tick) begin
      if (s.wd_secs + 16'h0001 >= s.wd_period) begin
        n.wd_secs = 16'h0000;
        n.wd_expired = 1'b1;
        // saturating count; event applied after a same-cycle write
        if (n.wd_events != 16'hFFFF) begin
          n.wd_events = n.wd_events + 16'h0001;
        end
      end else begin
        n.wd_secs = s.wd_secs + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s <= '0;
      s.reset_cause <= MCR_CAUSE_POWER_ON;
      s.rx_ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign rx_ready_out = s.rx_ready;
  assign tx_valid_out = s.tx_valid;
  assign tx_data_out = s.tx_data;
  assign tx_last_out = s.tx_last;
  assign restore_web_out = s.restore_web;
  assign restore_id_out = s.restore_id;
  assign reboot_out = s.reboot;
  assign preset_load_out = s.preset_load;
  assign counter_preset_out = s.preset;
  assign host_wd_expired_out = s.wd_expired;
  assign nv_write_out = s.nv_write;
  assign nv_addr_out = s.nv_addr;
  assign nv_data_out = s.nv_data;
  assign tcp_timeout_en_out = s.tcp_en;
  assign tcp_timeout_sec_out = s.tcp_sec;
  assign sys_timeout_en_out = s.sys_en;
  assign sys_timeout_sec_out = s.sys_sec;

  sequence s_coil_on(logic [15:0] a);
    s.st == MCR_EXEC && fc == MCR_FC_WRITE_COIL && val == MCR_COIL_ON && cur_a == a;
  endsequence
  sequence s_exc_enter;
    s.st == MCR_CHECK ##1 (s.st == MCR_SEND && s.exc != 8'h00 && !s.tx_valid);
  endsequence

  property p_restore_web;
    @(posedge clk_in) disable iff (rst_in) s_coil_on(MCR_COIL_RESTORE_WEB) |=> restore_web_out;
  endproperty
  a_restore_web: assert property (p_restore_web) else $error("web restore missing");
  property p_restore_id;
    @(posedge clk_in) disable iff (rst_in) s_coil_on(MCR_COIL_RESTORE_ID) |=> restore_id_out;
  endproperty
  a_restore_id: assert property (p_restore_id) else $error("id restore missing");
  property p_reboot;
    @(posedge clk_in) disable iff (rst_in)
      s_coil_on(MCR_COIL_REBOOT) |=> reboot_out ##1 !reboot_out;
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot pulse wrong");
  property p_coil_zero;
    @(posedge clk_in) disable iff (rst_in)
      (s.st == MCR_EXEC && fc == MCR_FC_WRITE_COIL && val == 16'h0000)
      |=> !(restore_web_out || restore_id_out || reboot_out);
  endproperty
  a_coil_zero: assert property (p_coil_zero) else $error("zero coil acted");
  property p_preset;
    @(posedge clk_in) disable iff (rst_in)
      (we && wa == MCR_HR_COUNTER_PRESET) |=> preset_load_out && counter_preset_out == $past(wd);
  endproperty
  a_preset: assert property (p_preset) else $error("preset not loaded");
  property p_nv_period;
    @(posedge clk_in) disable iff (rst_in)
      (we && wa == MCR_HR_WD_PERIOD) |=> nv_write_out && nv_addr_out == MCR_HR_WD_PERIOD;
  endproperty
  a_nv_period: assert property (p_nv_period) else $error("period not stored");
  property p_wd_count;
    @(posedge clk_in) disable iff (rst_in)
      (host_wd_expired_out && !$past(we) && $past(s.wd_events) != 16'hFFFF)
      |-> s.wd_events == $past(s.wd_events) + 16'h0001;
  endproperty
  a_wd_count: assert property (p_wd_count) else $error("event count wrong");
  property p_tcp_default;
    @(posedge clk_in) disable iff (rst_in)
      (!rst_in && s.tcp_to == 16'h0000) ##1 s.tcp_to == 16'h0000
      |-> tcp_timeout_sec_out == TCP_DEFAULT_SEC;
  endproperty
  a_tcp_default: assert property (p_tcp_default) else $error("tcp default wrong");
  property p_exc_frame;
    @(posedge clk_in) disable iff (rst_in)
      s_exc_enter |-> s.txb[MCR_PDU_FC] == (fc | MCR_FC_ERROR) && s.txb[MCR_PDU_ADDR] == s.exc
      ##[1:2] tx_valid_out;
  endproperty
  a_exc_frame: assert property (p_exc_frame) else $error("error answer wrong");
endmodule

// >>> pkg/mcr_pkg.sv
package mcr_pkg;
  // Frame buffer and word limits
  localparam int MCR_BUF_BYTES = 32;
  localparam int MCR_MAX_WORDS = 8;
  // Byte positions inside a framed request or answer, header included
  localparam int MCR_HDR_LEN_LO = 5;
  localparam int MCR_HDR_BYTES = 6;
  localparam int MCR_PDU_UNIT = 6;
  localparam int MCR_PDU_FC = 7;
  localparam int MCR_PDU_ADDR = 8;
  localparam int MCR_PDU_CNT = 10;
  localparam int MCR_PDU_BCNT = 12;
  localparam int MCR_PDU_DATA = 13;
  localparam int MCR_PDU_RD_DATA = 9;
  localparam int MCR_EXC_LAST = 8;
  localparam int MCR_ECHO_LAST = 11;
  // Function codes and exception codes
  localparam logic [7:0] MCR_FC_READ_HOLD = 8'h03;
  localparam logic [7:0] MCR_FC_READ_INPUT = 8'h04;
  localparam logic [7:0] MCR_FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] MCR_FC_WRITE_REG = 8'h06;
  localparam logic [7:0] MCR_FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] MCR_FC_ERROR = 8'h80;
  localparam logic [7:0] MCR_EXC_BAD_FUNC = 8'h01;
  localparam logic [7:0] MCR_EXC_BAD_ADDR = 8'h02;
  localparam logic [7:0] MCR_EXC_BAD_VALUE = 8'h03;
  localparam logic [15:0] MCR_COIL_ON = 16'hFF00;
  // Coils, input registers, holding registers
  localparam logic [15:0] MCR_COIL_RESTORE_WEB = 16'h007F;
  localparam logic [15:0] MCR_COIL_RESTORE_ID = 16'h0080;
  localparam logic [15:0] MCR_COIL_REBOOT = 16'h0085;
  localparam logic [15:0] MCR_IR_FW_VERSION = 16'h0097;
  localparam logic [15:0] MCR_IR_COMM_STATUS = 16'h009E;
  localparam logic [15:0] MCR_IR_PAIR_STATUS = 16'h00A0;
  localparam logic [15:0] MCR_HR_COUNTER_PRESET = 16'h0032;
  localparam logic [15:0] MCR_HR_RESET_CAUSE = 16'h00FF;
  localparam logic [15:0] MCR_HR_WD_PERIOD = 16'h0101;
  localparam logic [15:0] MCR_HR_WD_EVENTS = 16'h0102;
  localparam logic [15:0] MCR_HR_MODULE_NAME = 16'h0103;
  localparam logic [15:0] MCR_HR_TCP_TIMEOUT = 16'h0107;
  localparam logic [15:0] MCR_HR_SYS_TIMEOUT = 16'h0108;
  // Reset cause codes and enable thresholds
  localparam logic [15:0] MCR_CAUSE_POWER_ON = 16'h0001;
  localparam logic [15:0] MCR_CAUSE_WATCHDOG = 16'h0002;
  localparam logic [15:0] MCR_CAUSE_COMMAND = 16'h0003;
  localparam logic [15:0] MCR_WD_MIN = 16'h0005;
  localparam logic [15:0] MCR_TCP_MIN = 16'h0005;
  localparam logic [15:0] MCR_SYS_MIN = 16'h001E;
  localparam logic [15:0] MCR_SETTING_RESET = 16'h0000;
  // One second in clock cycles
  localparam int MCR_SEC_NS = 1000000000;
  localparam int MCR_CLK_NS = 20;
  localparam int MCR_TICKS_PER_SEC = MCR_SEC_NS / MCR_CLK_NS;

  typedef enum logic [1:0] {MCR_RECV, MCR_CHECK, MCR_EXEC, MCR_SEND} mcr_state_e;
endpackage

// >>> verification/mcr_host_model.sv
module mcr_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Request stream
  output logic req_valid_out,
  output logic [7:0] req_data_out,
  input wire logic req_ready_in,
  // Answer stream
  input wire logic ans_valid_in,
  input wire logic [7:0] ans_data_in,
  input wire logic ans_last_in,
  output logic ans_ready_out,
  // Stall answers every other cycle
  input wire logic slow_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid_out = 1'b0;
    req_data_out = 8'h00;
    ans_ready_out = 1'b0;
  end
  // whole frames, one at a time
  task automatic xfer(input logic [7:0] req[$], output logic [7:0] ans[$], output bit hung);
    int n;
    ans = {};
    n = 0;
    while (rst_in !== 1'b0) @(posedge clk_in);
    foreach (req[i]) begin
      req_valid_out <= 1'b1;
      req_data_out <= req[i];
      do begin
        @(posedge clk_in);
        n++;
      end while (req_ready_in !== 1'b1 && n < 300);
    end
    // Released data line never shows a stale byte
    req_valid_out <= 1'b0;
    req_data_out <= ~req[req.size() - 1];
    ans_ready_out <= 1'b1;
    while (n < 600) begin
      @(posedge clk_in);
      n++;
      if (ans_valid_in === 1'b1 && ans_ready_out === 1'b1) begin
        ans.push_back(ans_data_in);
        if (ans_last_in === 1'b1) begin
          break;
        end
      end
      ans_ready_out <= slow_in ? ~ans_ready_out : 1'b1;
    end
    ans_ready_out <= 1'b0;
    hung = (n >= 600);
  endtask
endmodule

// >>> verification/mcr_regs_bench.sv
module mcr_regs_bench import mcr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Short second keeps watchdog runs brief
  localparam int TPS = 40;
  logic clk_in, rst_in, rx_valid, rx_ready, tx_valid, tx_last, tx_ready, slow, comm_to;
  logic [7:0] rx_data, tx_data;
  logic [1:0] pair;
  logic web, id, reboot, pload, wd_exp, nv_wr, tcp_en, sys_en;
  logic [15:0] preset, nv_addr, nv_data, tcp_sec, sys_sec;
  int num_errors = 0;
  int total_checks = 0;
  int pulses[6] = '{0, 0, 0, 0, 0, 0};
  logic [15:0] coils[3] = '{MCR_COIL_RESTORE_WEB, MCR_COIL_RESTORE_ID, MCR_COIL_REBOOT};
  logic [15:0] t_addr[6] = '{MCR_HR_TCP_TIMEOUT, MCR_HR_TCP_TIMEOUT, MCR_HR_TCP_TIMEOUT,
    MCR_HR_SYS_TIMEOUT, MCR_HR_SYS_TIMEOUT, MCR_HR_SYS_TIMEOUT};
  logic [15:0] t_val[6] = '{16'h0004, 16'h0005, 16'h0000, 16'h001D, 16'h001E, 16'h0000};
  logic [15:0] t_sec[6] = '{16'h0004, 16'h0005, 16'h003C, 16'h001D, 16'h001E, 16'h003C};
  logic [15:0] t_en[6] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0001, 16'h0001};

  mcr_regs #(.TICKS_PER_SEC(TPS)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_last_out(tx_last),
    .tx_ready_in(tx_ready), .comm_timeout_in(comm_to), .pair_status_in(pair),
    .restore_web_out(web), .restore_id_out(id), .reboot_out(reboot),
    .preset_load_out(pload), .counter_preset_out(preset), .host_wd_expired_out(wd_exp),
    .nv_write_out(nv_wr), .nv_addr_out(nv_addr), .nv_data_out(nv_data),
    .tcp_timeout_en_out(tcp_en), .tcp_timeout_sec_out(tcp_sec),
    .sys_timeout_en_out(sys_en), .sys_timeout_sec_out(sys_sec));

  mcr_host_model i_host (.clk_in(clk_in), .rst_in(rst_in), .req_valid_out(rx_valid),
    .req_data_out(rx_data), .req_ready_in(rx_ready), .ans_valid_in(tx_valid),
    .ans_data_in(tx_data), .ans_last_in(tx_last), .ans_ready_out(tx_ready),
    .slow_in(slow));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (web === 1'b1) pulses[0]++;
    if (id === 1'b1) pulses[1]++;
    if (reboot === 1'b1) pulses[2]++;
    if (pload === 1'b1) pulses[3]++;
    if (nv_wr === 1'b1) pulses[4]++;
    if (wd_exp === 1'b1) pulses[5]++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sends one framed request and compares the whole answer frame
  task automatic run(input logic [7:0] pdu[$], input logic [7:0] exp[$]);
    logic [7:0] req[$];
    logic [7:0] ans[$];
    bit hung;
    req = {8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'(pdu.size() + 1), 8'h01, pdu};
    i_host.xfer(req, ans, hung);
    chk({15'h0000, hung}, 16'h0000);
    exp = {8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'(exp.size() + 1), 8'h01, exp};
    chk(16'(ans.size()), 16'(exp.size()));
    foreach (exp[i]) begin
      if (i < ans.size()) chk({8'h00, ans[i]}, {8'h00, exp[i]});
    end
  endtask

  task automatic rd(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    run({fc, a[15:8], a[7:0], 8'h00, 8'h01}, {fc, 8'h02, v[15:8], v[7:0]});
  endtask

  task automatic wr(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] v);
    run({fc, a[15:8], a[7:0], v[15:8], v[7:0]}, {fc, a[15:8], a[7:0], v[15:8], v[7:0]});
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    chk(16'hFFFF, 16'h0000);
    stop_test();
  end

  initial begin
    rst_in = 1'b1;
    slow = 1'b0;
    comm_to = 1'b1;
    pair = 2'h2;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    // Defaults load at the first edge after release; read them one edge later
    repeat (2) @(posedge clk_in);
    chk(tcp_sec, 16'h003C);
    chk(sys_sec, 16'h003C);
    rd(8'h03, MCR_HR_RESET_CAUSE, 16'h0001);
    rd(8'h04, MCR_IR_FW_VERSION, 16'h007B);
    rd(8'h04, MCR_IR_COMM_STATUS, 16'h0001);
    rd(8'h04, MCR_IR_PAIR_STATUS, 16'h0002);
    comm_to <= 1'b0;
    pair <= 2'h1;
    rd(8'h04, MCR_IR_COMM_STATUS, 16'h0000);
    rd(8'h04, MCR_IR_PAIR_STATUS, 16'h0001);
    run({8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h83, 8'h02});
    run({8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, {8'h81, 8'h01});
    $display("test status done");
    run({8'h10, 8'h00, 8'h32, 8'h00, 8'h01, 8'h02, 8'h03, 8'hE8},
      {8'h10, 8'h00, 8'h32, 8'h00, 8'h01});
    chk(preset, 16'h03E8);
    chk(16'(pulses[3]), 16'h0001);
    rd(8'h03, MCR_HR_COUNTER_PRESET, 16'h03E8);
    run({8'h10, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00}, {8'h90, 8'h03});
    $display("test multi write done");
    slow <= 1'b1;
    foreach (coils[i]) begin
      wr(8'h05, coils[i], 16'h0000);
      chk(16'(pulses[i]), 16'h0000);
      wr(8'h05, coils[i], MCR_COIL_ON);
      chk(16'(pulses[i]), 16'h0001);
    end
    slow <= 1'b0;
    $display("test coils done");
    foreach (t_addr[i]) begin
      wr(8'h06, t_addr[i], t_val[i]);
      chk(t_addr[i] == MCR_HR_TCP_TIMEOUT ? tcp_sec : sys_sec, t_sec[i]);
      chk({15'h0000, t_addr[i] == MCR_HR_TCP_TIMEOUT ? tcp_en : sys_en}, t_en[i]);
      chk(nv_addr, t_addr[i]);
      chk(nv_data, t_val[i]);
      chk(16'(pulses[4]), 16'(i + 1));
    end
    $display("test timeouts done");
    wr(8'h06, MCR_HR_WD_PERIOD, 16'h0005);
    chk(nv_addr, MCR_HR_WD_PERIOD);
    chk(16'(pulses[4]), 16'h0007);
    repeat (260) @(posedge clk_in);
    chk(16'(pulses[5]), 16'h0001);
    rd(8'h03, MCR_HR_WD_EVENTS, 16'h0001);
    wr(8'h06, MCR_HR_WD_EVENTS, 16'h0000);
    wr(8'h06, MCR_HR_WD_PERIOD, 16'h0004);
    repeat (260) @(posedge clk_in);
    rd(8'h03, MCR_HR_WD_EVENTS, 16'h0000);
    chk(16'(pulses[5]), 16'h0001);
    run({8'h03, 8'h01, 8'h01, 8'h00, 8'h02},
      {8'h03, 8'h04, 8'h00, 8'h04, 8'h00, 8'h00});
    $display("test watchdog done");
    stop_test();
  end
endmodule
